// ===== swd_pkg.sv
`default_nettype none
package swd_pkg;

  localparam int unsigned SWD_CNT_W = 16;
  localparam int unsigned SWD_PRE_W = 14;
  localparam int unsigned SWD_DIV_SLOW = 16384;
  localparam int unsigned SWD_DIV_FAST = 256;

  // reset defaults: divide by 256 and 254 counts to overflow
  localparam logic SWD_SEL_FAST = 1'b1;
  localparam logic SWD_SEL_RST = SWD_SEL_FAST;
  localparam logic [SWD_CNT_W-1:0] SWD_RELOAD_RST = 16'hff02;
  localparam logic [SWD_CNT_W-1:0] SWD_CNT_MAX = 16'hffff;

  localparam int unsigned SWD_CLK_PERIOD_NS = 10;
  localparam int unsigned SWD_PREWARN_NS = 80;
  localparam int unsigned SWD_PREWARN_CYC = (SWD_PREWARN_NS / SWD_CLK_PERIOD_NS < 1) ? 1 :
    SWD_PREWARN_NS / SWD_CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    SWD_RUN,
    SWD_WARN
  } swd_state_t;

endpackage
`default_nettype wire

// ===== swd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module swd_prescaler
  import swd_pkg::*;
#(
  parameter int unsigned PRE_W = SWD_PRE_W,
  parameter int unsigned DIV_SLOW = SWD_DIV_SLOW,
  parameter int unsigned DIV_FAST = SWD_DIV_FAST
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic sel_fast_i,
  // status
  output logic tick_o,
  output logic [PRE_W-1:0] count_o
);

  generate
    if (DIV_SLOW > (2 ** PRE_W) || DIV_FAST > (2 ** PRE_W) || DIV_FAST < 2)
    begin : g_bad_div
      $error("prescaler divider does not fit the counter");
    end
  endgenerate

  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] last;

  assign last = sel_fast_i ? PRE_W'(DIV_FAST - 1) : PRE_W'(DIV_SLOW - 1);
  assign tick_o = run_i && !clear_i && (cnt_q >= last);
  assign count_o = cnt_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= '0;
    end
    else if (clear_i || tick_o)
    begin
      cnt_q <= '0;
    end
    else if (run_i)
    begin
      cnt_q <= cnt_q + PRE_W'(1);
    end
  end

endmodule // swd_prescaler
`default_nettype wire

// ===== swd_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swd_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic dis = 1'b0;
  logic en = 1'b0;
  logic srv = 1'b0;
  logic cfg = 1'b0;
  logic fast = 1'b1;
  logic [SWD_CNT_W-1:0] rel = 16'hff02;
  logic en_o;
  logic pw;
  logic rr;
  logic [SWD_CNT_W-1:0] cnt;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  swd_watchdog i_dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .watchdog_disable_instruction_i(dis),
    .watchdog_enable_instruction_i(en),
    .service_i(srv),
    .cfg_wr_i(cfg),
    .watchdog_reload_value_i(rel),
    .presc_fast_i(fast),
    .enabled_o(en_o),
    .count_o(cnt),
    .prewarn_o(pw),
    .reset_req_o(rr)
  );

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic do_reset();
    nrst_i = 1'b0;
    wt(16);
    nrst_i = 1'b1;
  endtask

  // reset state, then first prescaler tick after 256 clocks
  task automatic t_reset();
    do_reset();
    chk("enabled", 16'(en_o), 16'h0001);
    chk("count", cnt, 16'hff02);
    chk("reqs", 16'({pw, rr}), 16'h0000);
    wt(255);
    chk("count", cnt, 16'hff02);
    wt(1);
    chk("count", cnt, 16'hff03);
    $display("test reset done");
  endtask

  // slow divider, overflow, prewarning then request
  task automatic t_overflow();
    rel = 16'hffff;
    fast = 1'b0;
    cfg = 1'b1;
    wt(1);
    cfg = 1'b0;
    srv = 1'b1;
    wt(1);
    srv = 1'b0;
    chk("count", cnt, 16'hffff);
    wt(16383);
    chk("count", cnt, 16'hffff);
    chk("prewarn", 16'(pw), 16'h0000);
    wt(1);
    chk("count", cnt, 16'h0000);
    chk("prewarn", 16'(pw), 16'h0001);
    wt(1);
    chk("prewarn", 16'(pw), 16'h0000);
    wt(6);
    chk("request", 16'(rr), 16'h0000);
    wt(1);
    chk("request", 16'(rr), 16'h0001);
    $display("test overflow done");
  endtask

  // disable holds everything; service reloads and clears prescaler
  task automatic t_disable();
    do_reset();
    dis = 1'b1;
    wt(1);
    dis = 1'b0;
    chk("enabled", 16'(en_o), 16'h0000);
    wt(600);
    chk("count", cnt, 16'hff02);
    chk("reqs", 16'({pw, rr}), 16'h0000);
    dis = 1'b1;
    en = 1'b1;
    wt(1);
    dis = 1'b0;
    en = 1'b0;
    chk("enabled", 16'(en_o), 16'h0001);
    rel = 16'hff10;
    fast = 1'b1;
    cfg = 1'b1;
    wt(1);
    cfg = 1'b0;
    wt(100);
    srv = 1'b1;
    wt(1);
    srv = 1'b0;
    chk("count", cnt, 16'hff10);
    wt(255);
    chk("count", cnt, 16'hff10);
    wt(1);
    chk("count", cnt, 16'hff11);
    $display("test disable done");
  endtask

  // disable in the prewarning delay cancels the request; service still reloads
  task automatic t_cancel();
    rel = 16'hffff;
    cfg = 1'b1;
    wt(1);
    cfg = 1'b0;
    srv = 1'b1;
    wt(1);
    srv = 1'b0;
    wt(255);
    chk("prewarn", 16'(pw), 16'h0000);
    wt(1);
    chk("prewarn", 16'(pw), 16'h0001);
    dis = 1'b1;
    wt(1);
    dis = 1'b0;
    wt(20);
    chk("request", 16'(rr), 16'h0000);
    chk("count", cnt, 16'h0000);
    srv = 1'b1;
    wt(1);
    srv = 1'b0;
    chk("count", cnt, 16'hffff);
    wt(300);
    chk("reqs", 16'({pw, rr}), 16'h0000);
    chk("count", cnt, 16'hffff);
    $display("test cancel done");
  endtask

  initial
  begin
    t_reset();
    t_overflow();
    t_disable();
    t_cancel();
    results();
  end
endmodule // tb
`default_nettype wire

// ===== swd_watchdog.sv
// Overview of operation
// [R1] comes up enabled and counting after reset
// [R2] disable and enable instructions stop or restart it
// [R3] overflow gives prewarning, then a reset request
// [R4] watchdog counter is sixteen bits wide
// [R5] counts once per 16384 or 256 clocks
// [R6] loads from a software-programmable reload value
// [R7] service reloads counter and clears prescaler
// [R8] reset defaults give 6.5 ms at 10 MHz
// [R9] counts upward, overflow on wrap to zero
// [R10] disabled: hold counts, no prewarning or request; a request already raised stays set until reset
`timescale 1ns/1ps
`default_nettype none
module swd_watchdog
  import swd_pkg::*;
#(
  parameter int unsigned CNT_W = SWD_CNT_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // instructions from the core
  input wire logic watchdog_disable_instruction_i,
  input wire logic watchdog_enable_instruction_i,
  input wire logic service_i,
  // configuration
  input wire logic cfg_wr_i,
  input wire logic [CNT_W-1:0] watchdog_reload_value_i,
  input wire logic presc_fast_i,
  // status and requests
  output logic enabled_o,
  output logic [CNT_W-1:0] count_o,
  output logic prewarn_o,
  output logic reset_req_o
);

  generate
    if (CNT_W != SWD_CNT_W)
    begin : g_bad_width
      $error("watchdog counter must be sixteen bits");
    end
  endgenerate

  localparam int unsigned DLY_W = $clog2(SWD_PREWARN_CYC + 1);

  logic en_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reload_q;
  logic sel_fast_q;
  logic prewarn_q;
  logic reset_req_q;
  swd_state_t state_q;
  logic [DLY_W-1:0] dly_q;
  logic tick;
  logic ovf;
  logic [SWD_PRE_W-1:0] pre_cnt;

  swd_prescaler #(
    .PRE_W(SWD_PRE_W),
    .DIV_SLOW(SWD_DIV_SLOW),
    .DIV_FAST(SWD_DIV_FAST)
  ) u_pre (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(en_q),
    .clear_i(service_i),
    .sel_fast_i(sel_fast_q),
    .tick_o(tick),
    .count_o(pre_cnt)
  );

  // enable wins when both instructions meet
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      en_q <= 1'b1; // [R1]
    end
    else if (watchdog_enable_instruction_i)
    begin
      en_q <= 1'b1; // [R2]
    end
    else if (watchdog_disable_instruction_i)
    begin
      en_q <= 1'b0; // [R2]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reload_q <= SWD_RELOAD_RST; // [R8]
      sel_fast_q <= SWD_SEL_RST; // [R8]
    end
    else if (cfg_wr_i)
    begin
      reload_q <= watchdog_reload_value_i; // [R6]
      sel_fast_q <= presc_fast_i; // [R5]
    end
  end

  assign ovf = en_q && tick && !service_i && (cnt_q == SWD_CNT_MAX); // [R9]

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= SWD_RELOAD_RST; // [R8]
    end
    else if (service_i)
    begin
      cnt_q <= reload_q; // [R7]
    end
    else if (en_q && tick)
    begin
      cnt_q <= cnt_q + CNT_W'(1); // [R4] [R5] [R9]
    end
  end

  // prewarning first, request after a fixed delay; disabling cancels it
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= SWD_RUN;
      dly_q <= '0;
      prewarn_q <= 1'b0;
      reset_req_q <= 1'b0;
    end
    else
    begin
      prewarn_q <= 1'b0;
      unique case (state_q)
        SWD_RUN:
        begin
          if (ovf)
          begin
            prewarn_q <= 1'b1; // [R3]
            state_q <= SWD_WARN;
            dly_q <= DLY_W'(SWD_PREWARN_CYC);
          end
        end
        SWD_WARN:
        begin
          if (!en_q)
          begin
            state_q <= SWD_RUN; // [R10]
            dly_q <= '0;
          end
          else if (dly_q > DLY_W'(1))
          begin
            dly_q <= dly_q - DLY_W'(1);
          end
          else
          begin
            reset_req_q <= 1'b1; // [R3]
          end
        end
      endcase
    end
  end

  assign enabled_o = en_q;
  assign count_o = cnt_q;
  assign prewarn_o = prewarn_q;
  assign reset_req_o = reset_req_q;

  logic first_q;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
    end
  end

  a_enabled_after_reset: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R1]
    first_q |-> en_q)
    else $error("watchdog not enabled after reset");

  a_disable_stops_counter: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R2]
    (watchdog_disable_instruction_i && !watchdog_enable_instruction_i) |=> !enabled_o)
    else $error("disable instruction ignored");

  a_enable_restarts_counter: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R2]
    watchdog_enable_instruction_i |=> enabled_o)
    else $error("enable instruction ignored");

  a_overflow_gives_prewarn: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R3]
    (ovf && state_q == SWD_RUN) |=> prewarn_o ##1 !prewarn_o)
    else $error("overflow without one-cycle prewarning");

  a_prewarn_before_request: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R3]
    $rose(reset_req_o) |-> $past(state_q) == SWD_WARN && !prewarn_o)
    else $error("reset request without prior prewarning");

  a_request_after_delay: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R3]
    (prewarn_o && en_q && !watchdog_disable_instruction_i) ##1
      (en_q && !watchdog_disable_instruction_i)[*7] |=> reset_req_o)
    else $error("reset request late after prewarning");

  a_count_step_up: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R9]
    (en_q && tick && !service_i) |=> count_o == CNT_W'($past(count_o) + CNT_W'(1)))
    else $error("counter did not step up by one");

  a_service_reloads: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R7]
    service_i |=> count_o == $past(reload_q) && pre_cnt == '0)
    else $error("service did not reload counter and clear prescaler");

  // first tick right after a switch to fast may come early
  a_fast_tick_period: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R5]
    (tick && sel_fast_q && $past(sel_fast_q)) |-> pre_cnt == SWD_PRE_W'(SWD_DIV_FAST - 1))
    else $error("fast prescaler tick off period");

  a_hold_while_disabled: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R10]
    (!en_q && !service_i) |=> $stable(count_o) && $stable(pre_cnt) && !prewarn_o)
    else $error("watchdog moved while disabled");

endmodule // swd_watchdog
`default_nettype wire
